// ---- accel_irq_cfg.svh ----
`ifndef ACCEL_IRQ_CFG_SVH
`define ACCEL_IRQ_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// Register offsets
`define ADDR_ENABLE_GRP0 8'h16
`define ADDR_ENABLE_GRP1 8'h17
`define ADDR_ENABLE_GRP2 8'h18
`define ADDR_PIN_A_ROUTE 8'h19
`define ADDR_FIFO_ROUTE 8'h1a
`define ADDR_PIN_B_ROUTE 8'h1b
`define ADDR_SOURCE_SEL 8'h1e
`define ADDR_OUT_CTRL 8'h20

////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_ZERO 8'h00
`define RST_OUT_CTRL 8'h05

////////////////////////////////////////////////////////////////////////////
// Writable bit masks, reserved bits read as zero
`define MASK_ENABLE_GRP0 8'hf7
`define MASK_ENABLE_GRP1 8'h7f
`define MASK_ENABLE_GRP2 8'h0f
`define MASK_FIFO_ROUTE 8'he7
`define MASK_SOURCE_SEL 8'h3f
`define MASK_OUT_CTRL 8'h0f

////////////////////////////////////////////////////////////////////////////
// Event vector positions (motion events follow the route register bits)
`define EVT_LOWG 0
`define EVT_HIGHG 1
`define EVT_ANYMOTION 2
`define EVT_STILLNESS 3
`define EVT_DOUBLE_TAP 4
`define EVT_SINGLE_TAP 5
`define EVT_ORIENTATION 6
`define EVT_FLAT 7
`define EVT_NEWSAMPLE 8
`define EVT_WATERMARK 9
`define EVT_QUEUE_FULL 10
`define EVT_COUNT 11

////////////////////////////////////////////////////////////////////////////
// Field positions
`define FIFO_A_NEWSAMPLE 0
`define FIFO_A_WATERMARK 1
`define FIFO_A_QUEUE_FULL 2
`define FIFO_B_QUEUE_FULL 5
`define FIFO_B_WATERMARK 6
`define FIFO_B_NEWSAMPLE 7
`define SRC_NEWSAMPLE 5
`define OUT_A_POLARITY 0
`define OUT_A_OPEN_DRAIN 1
`define OUT_B_POLARITY 2
`define OUT_B_OPEN_DRAIN 3
`define STILL_MODE_SEL 3
`define PIN_COUNT 2

`endif

// ---- accel_irq_pkg.sv ----
package accel_irq_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [10:0] event_vec_t;
  typedef logic [5:0] source_sel_t;
  typedef enum logic [0:0] {
    PIN_A = 1'b0,
    PIN_B = 1'b1
  } pin_sel_t;
endpackage

// ---- pin_route_if.sv ----
`timescale 1ns/100ps
interface pin_route_if;
  accel_irq_pkg::event_vec_t hit [2];
  logic [1:0] polarity;
  logic [1:0] open_drain;
  logic [1:0] active;
  logic [1:0] pin_o;
  logic [1:0] pin_oe;
  modport router (output hit, output polarity, output open_drain,
                  input active, input pin_o, input pin_oe);
  modport driver (input hit, input polarity, input open_drain,
                  output active, output pin_o, output pin_oe);
endinterface

// ---- pin_drive.sv ----
`timescale 1ns/100ps
`include "accel_irq_cfg.svh"
module pin_drive (
  input wire logic clock,
  input wire logic rst,
  pin_route_if.driver link
);
  logic [1:0] active_q;
  logic [1:0] pin_q;
  logic [1:0] active_d;
  logic [1:0] pin_d;

  ////////////////////////////////////////////////////////////////////////
  genvar p;
  generate
    for (p = 0; p < `PIN_COUNT; p = p + 1) begin : g_pin
      assign active_d[p] = |link.hit[p];
      assign pin_d[p] = ~(link.polarity[p] ^ active_d[p]);
      // Open drain only ever pulls the line low
      assign link.pin_oe[p] = ~link.open_drain[p] | ~pin_q[p];
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_q <= 2'h0;
      pin_q <= 2'h0;
    end else begin
      active_q <= active_d;
      pin_q <= pin_d;
    end
  end

  assign link.active = active_q;
  assign link.pin_o = pin_q;

  ////////////////////////////////////////////////////////////////////////
  a_level_follows_pol: assert property (
    @(posedge clock) disable iff (rst)
    ##1 pin_q[0] == ($past(link.polarity[0]) ~^ active_q[0]))
    else $error("pin A level does not follow polarity");

  a_any_hit_asserts: assert property (
    @(posedge clock) disable iff (rst)
    (|link.hit[1]) |=> active_q[1])
    else $error("pin B not asserted for a mapped event");

  a_no_hit_quiet: assert property (
    @(posedge clock) disable iff (rst)
    (link.hit[0] == '0) |=> !active_q[0])
    else $error("pin A asserted with no mapped event");
endmodule

// ---- accel_interrupt_routing.sv ----
`timescale 1ns/100ps
`include "accel_irq_cfg.svh"

// Overview of operation
// - Flat drives pin A on route A bit 7 and pin B on route B bit 7.
// - Orientation follows route bit 6 of each pin, 1 routed, 0 blocked.
// - Single tap follows route bit 5 of each pin.
// - Double tap follows route bit 4 of each pin.
// - Stillness follows route bit 3 of each pin.
// - Any-motion follows route bit 2 of each pin.
// - High-g follows route bit 1 of each pin.
// - Low-g follows route bit 0 of each pin.
// - New-sample goes to pin B on FIFO route bit 7, pin A on bit 0.
// - Watermark goes to pin B on FIFO route bit 6, pin A on bit 1.
// - Queue full goes to pin B on FIFO route bit 5, pin A on bit 2.
// - Source select bit 5 picks unfiltered (1) samples for new-sample.
// - Source bits 4 to 0 pick unfiltered data per engine, tap to low-g.
// - Only an event whose engine is enabled may reach a pin.
// - Each pin's asserted level follows its polarity bit, 1 high.
module accel_interrupt_routing (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [10:0] engine_event,
  output logic [10:0] engine_enable,
  output logic stillness_no_motion,
  output logic [5:0] source_unfiltered,
  output logic irq_pin_a_o,
  output logic irq_pin_a_oe,
  output logic irq_pin_b_o,
  output logic irq_pin_b_oe
);
  accel_irq_pkg::reg_byte_t enable0_q;
  accel_irq_pkg::reg_byte_t enable1_q;
  accel_irq_pkg::reg_byte_t enable2_q;
  accel_irq_pkg::reg_byte_t pin_a_motion_route_q;
  accel_irq_pkg::reg_byte_t fifo_data_route_q;
  accel_irq_pkg::reg_byte_t pin_b_motion_route_q;
  accel_irq_pkg::reg_byte_t event_source_select_q;
  accel_irq_pkg::reg_byte_t out_ctrl_q;
  accel_irq_pkg::reg_byte_t rdata_q;
  accel_irq_pkg::reg_byte_t rdata_d;
  accel_irq_pkg::event_vec_t gated;
  accel_irq_pkg::event_vec_t route_a;
  accel_irq_pkg::event_vec_t route_b;

  pin_route_if link ();

  ////////////////////////////////////////////////////////////////////////
  // Register writes, reserved bits are never stored
  wire wr_en0 = reg_wr && (reg_addr == `ADDR_ENABLE_GRP0);
  wire wr_en1 = reg_wr && (reg_addr == `ADDR_ENABLE_GRP1);
  wire wr_en2 = reg_wr && (reg_addr == `ADDR_ENABLE_GRP2);
  wire wr_route_a = reg_wr && (reg_addr == `ADDR_PIN_A_ROUTE);
  wire wr_fifo = reg_wr && (reg_addr == `ADDR_FIFO_ROUTE);
  wire wr_route_b = reg_wr && (reg_addr == `ADDR_PIN_B_ROUTE);
  wire wr_src = reg_wr && (reg_addr == `ADDR_SOURCE_SEL);
  wire wr_out = reg_wr && (reg_addr == `ADDR_OUT_CTRL);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable0_q <= `RST_ZERO;
      enable1_q <= `RST_ZERO;
      enable2_q <= `RST_ZERO;
      pin_a_motion_route_q <= `RST_ZERO;
      fifo_data_route_q <= `RST_ZERO;
      pin_b_motion_route_q <= `RST_ZERO;
      event_source_select_q <= `RST_ZERO;
      out_ctrl_q <= `RST_OUT_CTRL;
    end else begin
      if (wr_en0) enable0_q <= reg_wdata & `MASK_ENABLE_GRP0;
      if (wr_en1) enable1_q <= reg_wdata & `MASK_ENABLE_GRP1;
      if (wr_en2) enable2_q <= reg_wdata & `MASK_ENABLE_GRP2;
      if (wr_route_a) pin_a_motion_route_q <= reg_wdata;
      if (wr_fifo) fifo_data_route_q <= reg_wdata & `MASK_FIFO_ROUTE;
      if (wr_route_b) pin_b_motion_route_q <= reg_wdata;
      if (wr_src) event_source_select_q <= reg_wdata & `MASK_SOURCE_SEL;
      if (wr_out) out_ctrl_q <= reg_wdata & `MASK_OUT_CTRL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path, unmapped offsets read zero
  assign rdata_d =
    (reg_addr == `ADDR_ENABLE_GRP0) ? enable0_q :
    (reg_addr == `ADDR_ENABLE_GRP1) ? enable1_q :
    (reg_addr == `ADDR_ENABLE_GRP2) ? enable2_q :
    (reg_addr == `ADDR_PIN_A_ROUTE) ? pin_a_motion_route_q :
    (reg_addr == `ADDR_FIFO_ROUTE) ? fifo_data_route_q :
    (reg_addr == `ADDR_PIN_B_ROUTE) ? pin_b_motion_route_q :
    (reg_addr == `ADDR_SOURCE_SEL) ? event_source_select_q :
    (reg_addr == `ADDR_OUT_CTRL) ? out_ctrl_q : `RST_ZERO;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= `RST_ZERO;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Engine enables, multi-axis engines run when any axis is on
  assign engine_enable[`EVT_FLAT] = enable0_q[7];
  assign engine_enable[`EVT_ORIENTATION] = enable0_q[6];
  assign engine_enable[`EVT_SINGLE_TAP] = enable0_q[5];
  assign engine_enable[`EVT_DOUBLE_TAP] = enable0_q[4];
  assign engine_enable[`EVT_ANYMOTION] = |enable0_q[2:0];
  assign engine_enable[`EVT_WATERMARK] = enable1_q[6];
  assign engine_enable[`EVT_QUEUE_FULL] = enable1_q[5];
  assign engine_enable[`EVT_NEWSAMPLE] = enable1_q[4];
  assign engine_enable[`EVT_LOWG] = enable1_q[3];
  assign engine_enable[`EVT_HIGHG] = |enable1_q[2:0];
  assign engine_enable[`EVT_STILLNESS] = |enable2_q[2:0];
  assign stillness_no_motion = enable2_q[`STILL_MODE_SEL];

  assign source_unfiltered = event_source_select_q[5:0];

  assign gated = engine_event & engine_enable;

  ////////////////////////////////////////////////////////////////////////
  // Per-pin route vectors
  assign route_a = {fifo_data_route_q[`FIFO_A_QUEUE_FULL],
                    fifo_data_route_q[`FIFO_A_WATERMARK],
                    fifo_data_route_q[`FIFO_A_NEWSAMPLE],
                    pin_a_motion_route_q};
  assign route_b = {fifo_data_route_q[`FIFO_B_QUEUE_FULL],
                    fifo_data_route_q[`FIFO_B_WATERMARK],
                    fifo_data_route_q[`FIFO_B_NEWSAMPLE],
                    pin_b_motion_route_q};

  assign link.hit[accel_irq_pkg::PIN_A] = gated & route_a;
  assign link.hit[accel_irq_pkg::PIN_B] = gated & route_b;
  assign link.polarity = {out_ctrl_q[`OUT_B_POLARITY],
                          out_ctrl_q[`OUT_A_POLARITY]};
  assign link.open_drain = {out_ctrl_q[`OUT_B_OPEN_DRAIN],
                            out_ctrl_q[`OUT_A_OPEN_DRAIN]};

  pin_drive u_pin_drive (
    .clock(clock),
    .rst(rst),
    .link(link.driver)
  );

  assign irq_pin_a_o = link.pin_o[0];
  assign irq_pin_a_oe = link.pin_oe[0];
  assign irq_pin_b_o = link.pin_o[1];
  assign irq_pin_b_oe = link.pin_oe[1];

  ////////////////////////////////////////////////////////////////////////
  a_flat_route_a: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[7] && enable0_q[7] && pin_a_motion_route_q[7])
      |=> link.active[0])
    else $error("flat event missing on pin A");

  a_orient_route_b: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[6] && enable0_q[6] && pin_b_motion_route_q[6])
      |=> link.active[1])
    else $error("orientation event missing on pin B");

  a_orient_blocked_a: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event == 11'h040 && !pin_a_motion_route_q[6])
      |=> !link.active[0])
    else $error("blocked event reached pin A");

  a_stap_route_a: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[5] && enable0_q[5] && pin_a_motion_route_q[5])
      |=> link.active[0])
    else $error("single tap missing on pin A");

  a_dtap_route_b: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[4] && enable0_q[4] && pin_b_motion_route_q[4])
      |=> link.active[1])
    else $error("double tap missing on pin B");

  a_still_route_a: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[3] && enable2_q[0] && pin_a_motion_route_q[3])
      |=> link.active[0])
    else $error("stillness missing on pin A");

  a_slope_route_b: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[2] && enable0_q[1] && pin_b_motion_route_q[2])
      |=> link.active[1])
    else $error("any-motion missing on pin B");

  a_highg_route_a: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[1] && enable1_q[2] && pin_a_motion_route_q[1])
      |=> link.active[0])
    else $error("high-g missing on pin A");

  a_lowg_route_b: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[0] && enable1_q[3] && pin_b_motion_route_q[0])
      |=> link.active[1])
    else $error("low-g missing on pin B");

  a_sample_both_pins: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[8] && enable1_q[4] && fifo_data_route_q[7]
      && fifo_data_route_q[0]) |=> link.active == 2'h3)
    else $error("new-sample not on both pins");

  a_watermark_pin_b: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[9] && enable1_q[6] && fifo_data_route_q[6])
      |=> link.active[1])
    else $error("watermark missing on pin B");

  a_qfull_pin_a: assert property (
    @(posedge clock) disable iff (rst)
    (engine_event[10] && enable1_q[5] && fifo_data_route_q[2])
      |=> link.active[0])
    else $error("queue full missing on pin A");

  a_src_sample_sel: assert property (
    @(posedge clock) disable iff (rst)
    wr_src |=> source_unfiltered[5] == $past(reg_wdata[5]))
    else $error("new-sample source not updated");

  a_src_engine_sel: assert property (
    @(posedge clock) disable iff (rst)
    wr_src ##1 !wr_src [*2]
      |-> source_unfiltered[4:0] == $past(reg_wdata[4:0], 2))
    else $error("engine source select not held");

  a_disabled_blocked: assert property (
    @(posedge clock) disable iff (rst)
    (engine_enable == '0) |=> link.active == 2'h0)
    else $error("disabled engine reached a pin");
endmodule

// ---- irq_host_monitor.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Host side of the two interrupt lines, each with a board pull-up
module irq_host_monitor (
  input wire logic pin_a_o,
  input wire logic pin_a_oe,
  input wire logic pin_b_o,
  input wire logic pin_b_oe,
  output logic line_a,
  output logic line_b
);
  // A released open-drain line floats up to the pull-up level
  assign line_a = pin_a_oe ? pin_a_o : 1'b1;
  assign line_b = pin_b_oe ? pin_b_o : 1'b1;
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [10:0] engine_event = 11'h000;
  logic [10:0] engine_enable;
  logic stillness_no_motion;
  logic [5:0] source_unfiltered;
  logic irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o, irq_pin_b_oe;
  logic line_a, line_b;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] seed = 16'h0015;
  logic [7:0] mreg [256];
  logic [7:0] addrs [9] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b,
                            8'h1e, 8'h20, 8'h1c};

  always #20 clock = ~clock;

  accel_interrupt_routing uut (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_event(engine_event),
    .engine_enable(engine_enable), .stillness_no_motion(stillness_no_motion),
    .source_unfiltered(source_unfiltered), .irq_pin_a_o(irq_pin_a_o),
    .irq_pin_a_oe(irq_pin_a_oe), .irq_pin_b_o(irq_pin_b_o),
    .irq_pin_b_oe(irq_pin_b_oe));

  irq_host_monitor host (.pin_a_o(irq_pin_a_o), .pin_a_oe(irq_pin_a_oe),
    .pin_b_o(irq_pin_b_o), .pin_b_oe(irq_pin_b_oe),
    .line_a(line_a), .line_b(line_b));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  function automatic logic [7:0] mask_of(logic [7:0] a);
    case (a)
      8'h16: return 8'hf7;
      8'h17: return 8'h7f;
      8'h18: return 8'h0f;
      8'h19, 8'h1b: return 8'hff;
      8'h1a: return 8'he7;
      8'h1e: return 8'h3f;
      8'h20: return 8'h0f;
      default: return 8'h00;
    endcase
  endfunction

  // Multi-axis engines count as enabled when any axis bit is set
  function automatic logic [10:0] exp_enable();
    logic [7:0] e0, e1, e2;
    e0 = mreg[8'h16];
    e1 = mreg[8'h17];
    e2 = mreg[8'h18];
    return {e1[5], e1[6], e1[4], e0[7:4], |e2[2:0], |e0[2:0], |e1[2:0],
            e1[3]};
  endfunction

  // Returns {oe_b, o_b, oe_a, o_a}
  function automatic logic [3:0] exp_pins(logic [10:0] ev);
    logic [7:0] f, oc;
    logic [10:0] ra, rb;
    logic oa, ob;
    f = mreg[8'h1a];
    oc = mreg[8'h20];
    ra = {f[2], f[1], f[0], mreg[8'h19]};
    rb = {f[5], f[6], f[7], mreg[8'h1b]};
    oa = (|(ev & exp_enable() & ra)) ~^ oc[0];
    ob = (|(ev & exp_enable() & rb)) ~^ oc[2];
    return {oc[3] ? ~ob : 1'b1, ob, oc[1] ? ~oa : 1'b1, oa};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    mreg[a] = d & mask_of(a);
    @(negedge clock);
  endtask

  task automatic reg_read(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    check("reg_rdata", {8'h00, reg_rdata}, {8'h00, mreg[a]});
    @(negedge clock);
  endtask

  task automatic apply(input logic [10:0] ev);
    logic [3:0] p;
    engine_event = ev;
    @(negedge clock);
    p = exp_pins(ev);
    check("pin_a_o", {15'h0, irq_pin_a_o},
          {15'h0, p[0]});
    check("pin_b_o", {15'h0, irq_pin_b_o},
          {15'h0, p[2]});
    check("pin_oe", {14'h0, irq_pin_b_oe, irq_pin_a_oe},
          {14'h0, p[3], p[1]});
    check("wire", {14'h0, line_b, line_a},
          {14'h0, p[3] ? p[2] : 1'b1, p[1] ? p[0] : 1'b1});
    check("engine_enable", {5'h0, engine_enable},
          {5'h0, exp_enable()});
    check("source_unfiltered", {10'h0, source_unfiltered},
          {10'h0, mreg[8'h1e][5:0]});
    check("stillness", {15'h0, stillness_no_motion}, {15'h0, mreg[8'h18][3]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    logic [15:0] r;
    int i, p, k, n;
    foreach (mreg[j]) mreg[j] = 8'h00;
    mreg[8'h20] = 8'h05;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    apply(11'h000);
    foreach (addrs[j]) reg_read(addrs[j]);
    // Reserved bits and the unmapped place must not store
    foreach (addrs[j]) reg_write(addrs[j], 8'hff);
    foreach (addrs[j]) reg_read(addrs[j]);
    apply(11'h7ff);
    for (n = 0; n < 40; n++) begin
      foreach (addrs[j]) begin
        r = rnd();
        reg_write(addrs[j], r[7:0] & mask_of(addrs[j]));
      end
      for (k = 0; k < 8; k++) begin
        r = rnd();
        apply(r[10:0]);
      end
    end
    // One event routed to one pin, others active but unrouted
    reg_write(8'h16, 8'hf7);
    reg_write(8'h17, 8'h7f);
    reg_write(8'h18, 8'h0f);
    for (i = 0; i < 11; i++) begin
      for (p = 0; p < 2; p++) begin
        r = 16'h0001 << i;
        reg_write(8'h19, (p == 0 && i < 8) ? r[7:0] : 8'h00);
        reg_write(8'h1b, (p == 1 && i < 8) ? r[7:0] : 8'h00);
        reg_write(8'h1a, (i < 8) ? 8'h00 :
                  ((p == 0) ? r[15:8] : (8'h80 >> (i - 8))));
        apply(~r[10:0]);
        apply(r[10:0]);
      end
    end
    finish_test();
  end
endmodule
